// *** etr_pkg.sv ***
// Constants, types and helpers shared by the event record formatter.
package etr_pkg;
	// ***************************************************************
	// Widths and field positions.
	// ***************************************************************
	localparam int CHAR_W = 8;
	localparam int NIB_W = 4;
	localparam int FRAC_W = 5;
	localparam int EDGE_BYTES = 8;
	localparam int EDGE_TAG_BIT = 5;
	localparam int EDGE_ZERO_BIT = 6;
	localparam int EDGE_TRIG_BIT = 7;
	localparam int COUNT_W = 32;
	localparam logic [COUNT_W-1:0] COUNT_RST = 32'h0000_0000;
	localparam int STAT_W = 4;
	localparam int ST_PPS = 0;
	localparam int ST_TRIG = 1;
	localparam int ST_GPS = 2;
	localparam int ST_TOL = 3;
	localparam int HEX_DIG = 8;
	localparam int HMS_DIG = 6;
	localparam int MS_DIG = 3;
	localparam int DATE_DIG = 6;
	localparam int SATS_DIG = 2;
	localparam int CORR_DIG = 4;
	localparam int EDGE_TXT = 3;
	localparam int LINE_LEN = 74;
	localparam int LINE_W = LINE_LEN * CHAR_W;
	localparam int LEN_W = 7;
	localparam logic [LEN_W-1:0] LAST_CHAR = LEN_W'(LINE_LEN - 1);
	localparam int FIFO_DEPTH = 8;
	// ***************************************************************
	// Timing.
	// ***************************************************************
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int STAMP_HZ = 25_000_000;
	localparam int DIV_W = 2;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYS_CLK_HZ / STAMP_HZ - 1);
	localparam int PPS_TOL_DEF = 25;
	// ***************************************************************
	// Characters.
	// ***************************************************************
	localparam logic [CHAR_W-1:0] CH_SP = 8'h20;
	localparam logic [CHAR_W-1:0] CH_DOT = 8'h2e;
	localparam logic [CHAR_W-1:0] CH_CR = 8'h0d;
	localparam logic [CHAR_W-1:0] CH_LF = 8'h0a;
	localparam logic [CHAR_W-1:0] CH_A = 8'h41;
	localparam logic [CHAR_W-1:0] CH_V = 8'h56;
	localparam logic [CHAR_W-1:0] CH_PLUS = 8'h2b;
	localparam logic [CHAR_W-1:0] CH_MINUS = 8'h2d;
	localparam logic [CHAR_W-1:0] CH_ZERO = 8'h30;
	localparam logic [CHAR_W-1:0] CH_HEX_OFF = 8'h37;
	localparam logic [NIB_W-1:0] NIB_TEN = 4'ha;
	// Formatter sequence states.
	typedef enum logic [1:0] {S_IDLE, S_LOAD, S_SEND} etr_state_t;
	// Turns one nibble into an uppercase hex character.
	function automatic logic [CHAR_W-1:0] hex_char(input logic [NIB_W-1:0] n);
		logic [CHAR_W-1:0] c;
		c = (n < NIB_TEN) ? CH_ZERO + CHAR_W'(n) : CH_HEX_OFF + CHAR_W'(n);
		return c;
	endfunction
endpackage

// *** etr_fifo.sv ***
// Small character FIFO between the line formatter and the serial side.
`timescale 1ns/100ps
module etr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
	// Storage; read data comes straight from these flops.
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	logic push;
	logic pop;
	assign in_ready_o = (fill != FULL_CNT);
	assign out_valid_o = (fill != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_ptr];
	// Pointers wrap by hand so any depth works, not only powers of two.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
			end
		end
	end
	// Fill level; a simultaneous push and pop leaves it unchanged.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fill <= '0;
		end else if (push && !pop) begin
			fill <= fill + 1'b1;
		end else if (pop && !push) begin
			fill <= fill - 1'b1;
		end
	end
	// Data array has no reset; it is never read while empty.
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule

// *** etr_record.sv ***
// Event record formatter: timestamps, edge bytes and GPS fields to text lines.
`timescale 1ns/100ps
module etr_record #(
	parameter int unsigned PPS_NOM_TICKS = etr_pkg::STAMP_HZ,
	parameter int unsigned PPS_TOL_TICKS = etr_pkg::PPS_TOL_DEF
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic pps_i,
	input wire logic line_strobe_i,
	input wire logic line_new_trig_i,
	input wire logic [etr_pkg::EDGE_BYTES*etr_pkg::FRAC_W-1:0] edge_frac_i,
	input wire logic [etr_pkg::EDGE_BYTES-1:0] edge_valid_i,
	input wire logic [etr_pkg::HMS_DIG*etr_pkg::NIB_W-1:0] gps_hms_bcd_i,
	input wire logic [etr_pkg::MS_DIG*etr_pkg::NIB_W-1:0] gps_ms_bcd_i,
	input wire logic [etr_pkg::DATE_DIG*etr_pkg::NIB_W-1:0] gps_date_bcd_i,
	input wire logic gps_valid_i,
	input wire logic [etr_pkg::SATS_DIG*etr_pkg::NIB_W-1:0] gps_sats_bcd_i,
	input wire logic gps_write_busy_i,
	input wire logic corr_neg_i,
	input wire logic [etr_pkg::CORR_DIG*etr_pkg::NIB_W-1:0] corr_bcd_i,
	output logic line_ready_o,
	output logic char_valid_o,
	input wire logic char_ready_i,
	output logic [etr_pkg::CHAR_W-1:0] char_data_o,
	output logic [etr_pkg::COUNT_W-1:0] clock_count_o,
	output logic [etr_pkg::STAT_W-1:0] status_o
);
	import etr_pkg::*;
	// ***************************************************************
	// Declarations.
	// ***************************************************************

	localparam logic [COUNT_W-1:0] TOL_LO = COUNT_W'(PPS_NOM_TICKS - PPS_TOL_TICKS);
	localparam logic [COUNT_W-1:0] TOL_HI = COUNT_W'(PPS_NOM_TICKS + PPS_TOL_TICKS);

	// Prescaler that turns the core clock into timestamp ticks.
	logic [DIV_W-1:0] div_cnt;
	// One core cycle in every timestamp period.
	logic stamp_tick;
	// Free-running timestamp counter.
	logic [COUNT_W-1:0] stamp_cnt;
	// Count latched at the latest pulse-per-second.
	logic [COUNT_W-1:0] pps_cnt;
	// Set once a first pulse-per-second has been latched.
	logic pps_seen;
	// Last pulse interval was outside tolerance.
	logic pps_bad;
	// Counts between this pulse and the previous one.
	logic [COUNT_W-1:0] pps_delta;
	// Sticky pending flags, cleared when a line is taken.
	logic pps_pend;
	logic trig_pend;
	// Formatter state.
	etr_state_t state;
	// A line request accepted this cycle.
	logic line_take;
	// Snapshot of one line's fields.
	logic [COUNT_W-1:0] snap_trig;
	logic [COUNT_W-1:0] snap_pps;
	logic [CHAR_W-1:0] snap_edge [EDGE_BYTES];
	logic [HMS_DIG*NIB_W-1:0] snap_hms;
	logic [MS_DIG*NIB_W-1:0] snap_ms;
	logic [DATE_DIG*NIB_W-1:0] snap_date;
	logic snap_valid;
	logic [SATS_DIG*NIB_W-1:0] snap_sats;
	logic [STAT_W-1:0] snap_stat;
	logic snap_neg;
	logic [CORR_DIG*NIB_W-1:0] snap_corr;
	// Edge bytes built from the live inputs.
	logic [CHAR_W-1:0] edge_byte [EDGE_BYTES];
	// Text pieces of the line.
	logic [EDGE_BYTES*EDGE_TXT*CHAR_W-1:0] edge_txt;
	logic [HEX_DIG*CHAR_W-1:0] trig_txt;
	logic [HEX_DIG*CHAR_W-1:0] pps_txt;
	logic [HEX_DIG*CHAR_W-1:0] hms_full;
	logic [HEX_DIG*CHAR_W-1:0] ms_full;
	logic [HEX_DIG*CHAR_W-1:0] date_full;
	logic [HEX_DIG*CHAR_W-1:0] sats_full;
	logic [HEX_DIG*CHAR_W-1:0] corr_full;
	logic [CHAR_W-1:0] valid_char;
	logic [CHAR_W-1:0] sign_char;
	// Whole line, first character in the top byte.
	logic [LINE_W-1:0] line_chars;
	// Line being sent out, shifted one character at a time.
	logic [LINE_W-1:0] line_sh;
	// Index of the character now offered to the FIFO.
	logic [LEN_W-1:0] char_idx;
	// FIFO write side.
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [CHAR_W-1:0] fifo_in_data;
	// A character moved into the FIFO this cycle.
	logic char_push;

	// Turns a 32-bit word into eight uppercase hex characters.
	function automatic logic [HEX_DIG*CHAR_W-1:0] hex_txt(input logic [COUNT_W-1:0] v);
		logic [HEX_DIG*CHAR_W-1:0] t;
		t = '0;
		for (int i = 0; i < HEX_DIG; i++) begin
			t[i*CHAR_W +: CHAR_W] = hex_char(v[i*NIB_W +: NIB_W]);
		end
		return t;
	endfunction

	// ***************************************************************
	// Timestamp counter.
	// ***************************************************************

	// The prescaler keeps the counter at the timestamp rate, not the core rate.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt <= '0;
		end else if (div_cnt == DIV_LAST) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	assign stamp_tick = (div_cnt == DIV_LAST);

	// Counter runs free and wraps naturally through all ones.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stamp_cnt <= COUNT_RST;
		end else if (stamp_tick) begin
			stamp_cnt <= stamp_cnt + 1'b1;
		end
	end

	assign clock_count_o = stamp_cnt;

	// ***************************************************************
	// Pulse-per-second capture and tolerance check.
	// ***************************************************************

	assign pps_delta = stamp_cnt - pps_cnt;

	// Each pulse latches the count; the interval to the previous one is checked.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pps_cnt <= COUNT_RST;
			pps_seen <= 1'b0;
			pps_bad <= 1'b0;
		end else if (pps_i) begin
			pps_cnt <= stamp_cnt;
			pps_seen <= 1'b1;
			// The first pulse has no interval to judge, so it is not flagged.
			pps_bad <= pps_seen && ((pps_delta < TOL_LO) || (pps_delta > TOL_HI));
		end
	end

	// Pending flags; a pulse in the clearing cycle keeps pps_pend set, while the taken request clears trig_pend.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pps_pend <= 1'b0;
			trig_pend <= 1'b0;
		end else begin
			if (pps_i) begin
				pps_pend <= 1'b1;
			end else if (line_take) begin
				pps_pend <= 1'b0;
			end
			// A request that arrives while a line is busy is left pending.
			if (line_strobe_i && !line_take) begin
				trig_pend <= 1'b1;
			end else if (line_take) begin
				trig_pend <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// Edge byte assembly.
	// ***************************************************************

	// Byte order is rise then fall for channel zero up to channel three.
	generate
		for (genvar g = 0; g < EDGE_BYTES; g++) begin : g_edge
			always_comb begin
				edge_byte[g] = '0;
				edge_byte[g][FRAC_W-1:0] = edge_frac_i[g*FRAC_W +: FRAC_W];
				edge_byte[g][EDGE_TAG_BIT] = edge_valid_i[g];
				edge_byte[g][EDGE_ZERO_BIT] = 1'b0;
				edge_byte[g][EDGE_TRIG_BIT] = (g == 0) ? line_new_trig_i : 1'b0;
			end
			assign edge_txt[(EDGE_BYTES-g)*EDGE_TXT*CHAR_W-1 -: EDGE_TXT*CHAR_W] =
				{hex_char(snap_edge[g][CHAR_W-1 -: NIB_W]), hex_char(snap_edge[g][NIB_W-1:0]), CH_SP};
		end
	endgenerate

	// ***************************************************************
	// Line snapshot.
	// ***************************************************************

	assign line_take = line_strobe_i && (state == S_IDLE);
	assign line_ready_o = (state == S_IDLE);

	// All fields are frozen together so a line never mixes two moments.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			snap_trig <= COUNT_RST;
			snap_pps <= COUNT_RST;
			snap_hms <= '0;
			snap_ms <= '0;
			snap_date <= '0;
			snap_valid <= 1'b0;
			snap_sats <= '0;
			snap_stat <= '0;
			snap_neg <= 1'b0;
			snap_corr <= '0;
			for (int i = 0; i < EDGE_BYTES; i++) begin
				snap_edge[i] <= '0;
			end
		end else if (line_take) begin
			snap_trig <= stamp_cnt;
			snap_pps <= pps_i ? stamp_cnt : pps_cnt;
			snap_hms <= gps_hms_bcd_i;
			snap_ms <= gps_ms_bcd_i;
			snap_date <= gps_date_bcd_i;
			snap_valid <= gps_valid_i;
			snap_sats <= gps_sats_bcd_i;
			snap_stat[ST_PPS] <= pps_pend || pps_i;
			snap_stat[ST_TRIG] <= trig_pend;
			snap_stat[ST_GPS] <= gps_write_busy_i;
			snap_stat[ST_TOL] <= pps_bad;
			snap_neg <= corr_neg_i;
			snap_corr <= corr_bcd_i;
			for (int i = 0; i < EDGE_BYTES; i++) begin
				snap_edge[i] <= edge_byte[i];
			end
		end
	end

	assign status_o = snap_stat;

	// ***************************************************************
	// Text assembly.
	// ***************************************************************

	assign trig_txt = hex_txt(snap_trig);
	assign pps_txt = hex_txt(snap_pps);
	// Decimal fields are BCD, so hex conversion gives plain digits.
	assign hms_full = hex_txt(COUNT_W'(snap_hms));
	assign ms_full = hex_txt(COUNT_W'(snap_ms));
	assign date_full = hex_txt(COUNT_W'(snap_date));
	assign sats_full = hex_txt(COUNT_W'(snap_sats));
	assign corr_full = hex_txt(COUNT_W'(snap_corr));
	assign valid_char = snap_valid ? CH_A : CH_V;
	assign sign_char = snap_neg ? CH_MINUS : CH_PLUS;

	// Sixteen words separated by single spaces, closed by CR LF.
	assign line_chars = {
		trig_txt, CH_SP,
		edge_txt,
		pps_txt, CH_SP,
		hms_full[HMS_DIG*CHAR_W-1:0], CH_DOT, ms_full[MS_DIG*CHAR_W-1:0], CH_SP,
		date_full[DATE_DIG*CHAR_W-1:0], CH_SP,
		valid_char, CH_SP,
		sats_full[SATS_DIG*CHAR_W-1:0], CH_SP,
		hex_char(snap_stat), CH_SP,
		sign_char, corr_full[CORR_DIG*CHAR_W-1:0],
		CH_CR, CH_LF
	};

	// ***************************************************************
	// Line sequencer.
	// ***************************************************************

	// Idle takes a line, load copies its text, send feeds it out.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: begin
					if (line_take) begin
						state <= S_LOAD;
					end
				end
				S_LOAD: begin
					state <= S_SEND;
				end
				S_SEND: begin
					// Multi-line events simply arrive as further requests.
					if (char_push && (char_idx == LAST_CHAR)) begin
						state <= S_IDLE;
					end
				end
			endcase
		end
	end

	// A full FIFO stalls the shift, so no character is ever dropped.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			line_sh <= '0;
			char_idx <= '0;
		end else if (state == S_LOAD) begin
			line_sh <= line_chars;
			char_idx <= '0;
		end else if (char_push) begin
			line_sh <= {line_sh[LINE_W-CHAR_W-1:0], CH_SP};
			char_idx <= char_idx + 1'b1;
		end
	end

	assign fifo_in_valid = (state == S_SEND);
	assign fifo_in_data = line_sh[LINE_W-1 -: CHAR_W];
	assign char_push = fifo_in_valid && fifo_in_ready;

	// ***************************************************************
	// Output FIFO.
	// ***************************************************************

	etr_fifo #(
		.WIDTH(CHAR_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in_data),
		.out_valid_o(char_valid_o),
		.out_ready_i(char_ready_i),
		.out_data_o(char_data_o)
	);

	// ***************************************************************
	// Assertions.
	// ***************************************************************

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	trig_count_latch_a: assert property (line_take |=> snap_trig == $past(stamp_cnt))
		else $error("trigger count not latched");
	pps_count_latch_a: assert property (pps_i |=> pps_cnt == $past(stamp_cnt))
		else $error("pulse count not latched");
	edge_frac_copy_a: assert property (line_take |=>
		snap_edge[EDGE_BYTES-1][FRAC_W-1:0] == $past(edge_frac_i[EDGE_BYTES*FRAC_W-1 -: FRAC_W]))
		else $error("edge fraction mismatch");
	edge_tag_bit_a: assert property (line_take |=>
		snap_edge[0][EDGE_TAG_BIT] == $past(edge_valid_i[0]))
		else $error("edge tag mismatch");
	edge_zero_bit_a: assert property (state == S_SEND |->
		!snap_edge[0][EDGE_ZERO_BIT] && !snap_edge[EDGE_BYTES-1][EDGE_ZERO_BIT])
		else $error("edge bit six set");
	trig_flag_bit_a: assert property (line_take |=>
		snap_edge[0][EDGE_TRIG_BIT] == $past(line_new_trig_i) && !snap_edge[1][EDGE_TRIG_BIT])
		else $error("trigger flag misplaced");
	valid_char_a: assert property (line_take |=> valid_char == ($past(gps_valid_i) ? CH_A : CH_V))
		else $error("validity character wrong");
	pps_pend_set_a: assert property (pps_i || (pps_pend && !line_take) |=> pps_pend)
		else $error("pulse pending lost");
	stamp_rate_a: assert property (stamp_tick |=> stamp_cnt == $past(stamp_cnt) + 1'b1 ##1
		stamp_cnt == $past(stamp_cnt) [*3])
		else $error("stamp rate wrong");
	line_end_a: assert property (char_push && char_idx == LAST_CHAR |->
		fifo_in_data == CH_LF ##1 state == S_IDLE)
		else $error("line end wrong");

	line_sent_c: cover property (char_push && char_idx == LAST_CHAR);
	refused_req_c: cover property (line_strobe_i && !line_ready_o);
	pps_bad_c: cover property (pps_bad);
	fifo_stall_c: cover property (fifo_in_valid && !fifo_in_ready);
endmodule

// *** etr_host_model.sv ***
// Host-side sink model that accepts record characters and queues them for the bench.
`timescale 1ns/100ps
module etr_host_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [1:0] stall_mode_i,
	input wire logic char_valid_i,
	input wire logic [etr_pkg::CHAR_W-1:0] char_data_i,
	output logic char_ready_o
);
	import etr_pkg::*;
	// ***************************************************************
	// Receive side.
	// ***************************************************************
	logic [1:0] phase; // Free-running phase for the slow acceptance pattern.
	logic [CHAR_W-1:0] rx_q[$]; // Characters taken so far, oldest first.
	// Mode 0 takes every cycle, mode 1 every other cycle, mode 2 stalls fully.
	// A real host may stall for long stretches, so mode 2 has no limit of its own.
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			char_ready_o <= 1'b0;
			phase <= 2'h0;
			rx_q.delete();
		end else begin
			// A character moves only when both sides agree at this edge.
			if (char_valid_i && char_ready_o) begin
				rx_q.push_back(char_data_i);
			end
			phase <= phase + 2'h1;
			case (stall_mode_i)
				2'h0: char_ready_o <= 1'b1;
				2'h1: char_ready_o <= phase[0];
				default: char_ready_o <= 1'b0;
			endcase
		end
	end
endmodule

// *** etr_record_test.sv ***
// Self-checking bench for the event record formatter.
`timescale 1ns/100ps
module etr_record_test;
	import etr_pkg::*;
	// ***************************************************************
	// Bench signals and expectation state.
	// ***************************************************************
	localparam int NOM = 40; // Shortened nominal ticks per second.
	localparam int TOL = 2; // Shortened tolerance in ticks.
	logic clk, rst, pps, line_strobe, line_new_trig, gps_valid, gps_busy, corr_neg;
	logic [EDGE_BYTES*FRAC_W-1:0] edge_frac;
	logic [EDGE_BYTES-1:0] edge_valid;
	logic [23:0] gps_hms, gps_date;
	logic [11:0] gps_ms;
	logic [7:0] gps_sats;
	logic [15:0] corr;
	logic [1:0] host_mode;
	logic line_ready, char_valid, char_ready;
	logic [CHAR_W-1:0] char_data;
	logic [COUNT_W-1:0] clock_count, c1;
	logic [STAT_W-1:0] status;
	int edges, bad_count, samples_checked, last_tick;
	bit have_prev, pps_pend, trig_pend, tol_bad;
	logic [31:0] pps_val, tc;
	logic [3:0] st;
	string exp_line;
	// ***************************************************************
	// Design, host model and clock.
	// ***************************************************************
	etr_record #(.PPS_NOM_TICKS(NOM), .PPS_TOL_TICKS(TOL)) DUT (.core_clk_i(clk), .rst_i(rst), .pps_i(pps),
		.line_strobe_i(line_strobe), .line_new_trig_i(line_new_trig), .edge_frac_i(edge_frac),
		.edge_valid_i(edge_valid), .gps_hms_bcd_i(gps_hms), .gps_ms_bcd_i(gps_ms), .gps_date_bcd_i(gps_date),
		.gps_valid_i(gps_valid), .gps_sats_bcd_i(gps_sats), .gps_write_busy_i(gps_busy), .corr_neg_i(corr_neg),
		.corr_bcd_i(corr), .line_ready_o(line_ready), .char_valid_o(char_valid), .char_ready_i(char_ready),
		.char_data_o(char_data), .clock_count_o(clock_count), .status_o(status));
	etr_host_model host (.core_clk_i(clk), .rst_i(rst), .stall_mode_i(host_mode), .char_valid_i(char_valid),
		.char_data_i(char_data), .char_ready_o(char_ready));
	// The clock toggles every half period of 5 ns.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Edges since reset release; a take on edge k with k mod 4 equal to 1 latches (k-1)/4 either way.
	always @(posedge clk or posedge rst) begin
		if (rst) edges <= 0;
		else edges <= edges + 1;
	end
	// ***************************************************************
	// Shared helpers.
	// ***************************************************************
	// Counts a comparison and reports it at once when it differs.
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// Prints the counts and the verdict, then stops the run.
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// A wait that runs out counts as a mismatch and ends the run.
	task automatic fail(input string what);
		bad_count++;
		$display("unexpected wait %s: expected done seen timeout", what);
		conclude();
	endtask
	// Builds the text that one line must carry from the inputs the bench drives.
	function automatic string mk_line(logic [31:0] t, logic trig, logic [3:0] s4);
		string s;
		logic [7:0] b;
		s = $sformatf("%h ", t);
		for (int g = 0; g < EDGE_BYTES; g++) begin
			b = {trig && g == 0, 1'b0, edge_valid[g], edge_frac[g*FRAC_W +: FRAC_W]};
			s = {s, $sformatf("%h ", b)};
		end
		s = {s, $sformatf("%h %h.%h %h %s %h %h %s%h\r\n", pps_val, gps_hms, gps_ms, gps_date,
			gps_valid ? "A" : "V", gps_sats, s4, corr_neg ? "-" : "+", corr)};
		// Hex formatting may print lower case, so the whole line is raised to upper case.
		return s.toupper();
	endfunction
	// Sends one pulse-per-second dt ticks after the previous one, on a tick-aligned edge.
	task automatic pps_pulse(input int dt);
		int n;
		n = 0;
		if (!have_prev) last_tick = (edges + 1) / 4;
		do begin
			@(posedge clk);
			n++;
		end while (edges != 4 * (last_tick + dt) - 1 && n < 1000);
		if (n >= 1000) fail("pps slot");
		pps <= 1'b1;
		if (have_prev) tol_bad = (dt < NOM - TOL || dt > NOM + TOL);
		have_prev = 1'b1;
		last_tick += dt;
		pps_val = last_tick;
		pps_pend = 1'b1;
		@(posedge clk);
		pps <= 1'b0;
	endtask
	// Requests one line on a tick-aligned edge and records the text it must produce.
	task automatic take_line(input logic trig);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(line_ready === 1'b1 && edges % 4 == 3) && n < 400);
		if (n >= 400) fail("line ready");
		line_strobe <= 1'b1;
		line_new_trig <= trig;
		tc = (edges + 1) / 4;
		st = {tol_bad, gps_busy, trig_pend, pps_pend};
		exp_line = mk_line(tc, trig, st);
		pps_pend = 1'b0;
		trig_pend = 1'b0;
		@(posedge clk);
		line_strobe <= 1'b0;
	endtask
	// Waits for a whole line at the host and compares it character by character.
	task automatic get_line();
		int n;
		n = 0;
		while (host.rx_q.size() < LINE_LEN && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) fail("line text");
		#1;
		check("status", status, st);
		for (int i = 0; i < LINE_LEN; i++) begin
			check("line char", {24'h0, host.rx_q.pop_front()}, {24'h0, exp_line[i]});
		end
	endtask
	// ***************************************************************
	// Scenarios.
	// ***************************************************************
	// Full line with every edge present and a new trigger; also the count rate.
	task automatic t_format();
		@(posedge clk);
		edge_valid <= 8'hff;
		edge_frac <= {5'h1f, 5'h00, 5'h15, 5'h0a, 5'h01, 5'h10, 5'h07, 5'h1e};
		take_line(1'b1);
		get_line();
		#1;
		c1 = clock_count;
		repeat (400) @(posedge clk);
		#1;
		check("tick rate", clock_count - c1, 32'h64);
		$display("test format done");
	endtask
	// Pulse intervals inside and outside tolerance, pending flag set and cleared.
	task automatic t_pps();
		pps_pulse(2);
		take_line(1'b1);
		get_line();
		pps_pulse(NOM);
		pps_pulse(NOM + TOL + 3);
		take_line(1'b0);
		get_line();
		pps_pulse(NOM - TOL);
		take_line(1'b0);
		get_line();
		take_line(1'b0);
		get_line();
		$display("test pps done");
	endtask
	// A strobe while busy is refused and flagged on the next line; GPS invalid and busy.
	task automatic t_refuse();
		@(posedge clk);
		edge_valid <= 8'h5a;
		edge_frac <= {5'h00, 5'h09, 5'h00, 5'h1c, 5'h03, 5'h00, 5'h11, 5'h00};
		gps_valid <= 1'b0;
		gps_busy <= 1'b1;
		corr_neg <= 1'b1;
		corr <= 16'h0389;
		gps_sats <= 8'h04;
		take_line(1'b0);
		repeat (5) @(posedge clk);
		#1;
		check("ready busy", line_ready, 1'b0);
		@(posedge clk);
		line_strobe <= 1'b1;
		trig_pend = 1'b1;
		@(posedge clk);
		line_strobe <= 1'b0;
		get_line();
		take_line(1'b1);
		get_line();
		$display("test refuse done");
	endtask
	// The host stalls until the buffer refuses, then drains slowly.
	task automatic t_stall();
		@(posedge clk);
		host_mode <= 2'h2;
		take_line(1'b1);
		repeat (100) @(posedge clk);
		#1;
		check("stalled valid", char_valid, 1'b1);
		check("stalled ready", line_ready, 1'b0);
		@(posedge clk);
		host_mode <= 2'h1;
		get_line();
		@(posedge clk);
		host_mode <= 2'h0;
		$display("test stall done");
	endtask
	// ***************************************************************
	// Main sequence.
	// ***************************************************************
	initial begin
		rst = 1'b1;
		{pps, line_strobe, line_new_trig, gps_busy, corr_neg} = 5'h0;
		gps_valid = 1'b1;
		edge_frac = '0;
		edge_valid = 8'h00;
		gps_hms = 24'h235959;
		gps_ms = 12'h999;
		gps_date = 24'h311299;
		gps_sats = 8'h12;
		corr = 16'h0096;
		host_mode = 2'h0;
		pps_val = COUNT_RST;
		{bad_count, samples_checked} = 0;
		{have_prev, pps_pend, trig_pend, tol_bad} = 4'h0;
		repeat (10) @(posedge clk);
		#1;
		check("reset ready", line_ready, 1'b1);
		check("reset valid", char_valid, 1'b0);
		check("reset count", clock_count, COUNT_RST);
		check("reset status", status, 4'h0);
		rst <= 1'b0;
		t_format();
		t_pps();
		t_refuse();
		t_stall();
		conclude();
	end
endmodule
